// ==== chk_defines.svh ====
`ifndef CHK_DEFINES_SVH
`define CHK_DEFINES_SVH
// register byte offsets
`define OFF_CTRL     12'h000
`define OFF_REQ      12'h004
`define OFF_VLIMIT   12'h008
`define OFF_POS      12'h00c
`define OFF_VEL      12'h010
`define OFF_ERR      12'h014
`define OFF_STAT     12'h018
// request register fields
`define REQ_POS_BIT  0
`define REQ_VEL_BIT  1
`define REQ_AXIS_LSB 4
// reset values
`define RST_VLIMIT   32'h0000ffff
// error codes
`define ERR_NONE     16'd0
`define ERR_POS      16'd300
`define ERR_ZRET     16'd301
`define ERR_CIRC     16'd302
`define ERR_AUTODEC  16'd303
`define ERR_JOGDEC   16'd304
`define ERR_RANGE    16'd305
`define ERR_MIN      16'd300
`define ERR_MAX      16'd399
`endif

// ==== chk_pkg.sv ====
package chk_pkg;
	// ***********************
	// motion modes per axis
	// ***********************
	typedef enum logic [3:0] {
		MODE_IDLE, MODE_POSN, MODE_INCR, MODE_VELO, MODE_VPOS, MODE_VCHG,
		MODE_CVEL, MODE_JOG, MODE_MPG, MODE_ZRET, MODE_FOLLOW, MODE_CIRC
	} mode_t;
	// request kinds
	typedef enum logic [1:0] {REQ_NONE, REQ_POS, REQ_VEL} req_kind_t;
endpackage : chk_pkg

// ==== chk_if.sv ====
`timescale 1ns/1ps
// request and verdict between bus front end and checker core
interface chk_if;
	import chk_pkg::*;
	logic             req_valid; // one-cycle request pulse
	req_kind_t        req_kind;  // position or velocity change
	logic [2:0]       axis;      // target axis
	logic [31:0]      value;     // new position or velocity
	logic             done;      // one-cycle verdict pulse
	logic             accept;    // value applied (maybe clamped)
	logic [15:0]      code;      // error code, 0 if none
	logic [31:0]      applied;   // value actually applied
	modport front (output req_valid, req_kind, axis, value, input done, accept, code, applied);
	modport core  (input req_valid, req_kind, axis, value, output done, accept, code, applied);
endinterface : chk_if

// ==== chk_core.sv ====
`timescale 1ns/1ps
`include "chk_defines.svh"
// ***********************
// verdict logic for one request
// ***********************
module chk_core
	import chk_pkg::*;
#(
	parameter int AXES = 8 // axis count
)(
	input  wire logic                clk,             // system clock
	input  wire logic                rst_n,           // async reset, low
	chk_if.core                      bus,             // request / verdict
	input  wire logic [AXES-1:0]     start_accept_flag, // axis busy
	input  wire logic [AXES-1:0]     servo_ready_sync,  // servo ready, synced
	input  wire logic [AXES-1:0]     booted,          // start-up finished
	input  wire logic [AXES-1:0]     auto_decel,      // auto decel started
	input  wire logic [AXES-1:0]     jog_fwd_rev_sync, // jog start held
	input  wire logic [4*AXES-1:0]   mode_flat,       // per-axis mode
	input  wire logic [31:0]         vlimit           // velocity limit
);
	import chk_pkg::*;
	// refuse axis counts that the 3-bit axis field cannot address
	if (AXES < 1 || AXES > 8)
	begin : g_bad_axes
		$error("AXES must be 1..8");
	end

	typedef struct packed {
		logic        done;
		logic        accept;
		logic [15:0] code;
		logic [31:0] applied;
	} state_t;
	state_t s_r, s_nxt;
	mode_t  m; // mode of target axis

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		m = mode_t'(mode_flat[bus.axis*4 +: 4]);
		if (bus.req_valid)
		begin
			s_nxt.done = 1'b1;
			s_nxt.accept = 1'b1;
			s_nxt.code = `ERR_NONE;
			s_nxt.applied = bus.value;
			if (bus.req_kind == REQ_POS)
			begin
				// moving, not booted or servo off: refuse, keep position
				if (start_accept_flag[bus.axis] || !booted[bus.axis] || !servo_ready_sync[bus.axis])
				begin
					s_nxt.accept = 1'b0;
					s_nxt.code = `ERR_POS;
				end
			end
			else
			begin
				// priority order of refusals follows code order
				if (m == MODE_ZRET)
				begin
					s_nxt.accept = 1'b0;
					s_nxt.code = `ERR_ZRET;
				end
				else if (m == MODE_CIRC)
				begin
					s_nxt.accept = 1'b0;
					s_nxt.code = `ERR_CIRC;
				end
				else if (auto_decel[bus.axis])
				begin
					s_nxt.accept = 1'b0;
					s_nxt.code = `ERR_AUTODEC;
				end
				else if (m == MODE_JOG && !jog_fwd_rev_sync[bus.axis])
				begin
					s_nxt.accept = 1'b0;
					s_nxt.code = `ERR_JOGDEC;
				end
				// signed view: negative is out of range too
				else if (bus.value[31] || bus.value > vlimit)
				begin
					s_nxt.applied = vlimit;
					s_nxt.code = `ERR_RANGE;
				end
			end
		end
	end

	// register the verdict
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;

	assign bus.done    = s_r.done;
	assign bus.accept  = s_r.accept;
	assign bus.code    = s_r.code;
	assign bus.applied = s_r.applied;
endmodule : chk_core

// ==== axis_sync.sv ====
`timescale 1ns/1ps
// ***********************
// two-flop synchroniser for pin levels
// ***********************
module axis_sync #(
	parameter int W = 8 // bit count
)(
	input  wire logic         clk,   // system clock
	input  wire logic         rst_n, // async reset, low
	input  wire logic [W-1:0] d,     // async level in
	output logic      [W-1:0] q      // synced level out
);
	typedef struct packed {
		logic [W-1:0] m;
		logic [W-1:0] q;
	} state_t;
	state_t s_r, s_nxt;
	// first stage is read only by the second
	always_comb
	begin
		s_nxt.m = d;
		s_nxt.q = s_r.m;
	end
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	assign q = s_r.q;
endmodule : axis_sync

// ==== axis_change_request_checker.sv ====
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "chk_defines.svh"
// Function
// - error codes only in 300..399
// - position change while moving gives 300
// - position change before boot gives 300
// - refused position change keeps position
// - speed change during zero return: 301
// - speed change during circular move: 302
// - speed change after auto decel: 303
// - speed change in jog stop: 304
// - refused speed change keeps old speed
// - out-of-range speed: 305, use limit
module axis_change_request_checker
	import chk_pkg::*;
#(
	parameter int AXES = 8 // axis count
)(
	input  wire logic              pclk,              // system clock
	input  wire logic              presetn,           // async reset, low
	input  wire logic              psel,              // apb select
	input  wire logic              penable,           // apb enable
	input  wire logic              pwrite,            // apb direction
	input  wire logic [11:0]       paddr,             // apb address
	input  wire logic [31:0]       pwdata,            // apb write data
	output logic      [31:0]       prdata,            // apb read data
	output logic                   pready,            // apb ready
	output logic                   pslverr,           // apb error
	input  wire logic [AXES-1:0]   start_accept_flag, // axis busy, same clock
	input  wire logic [AXES-1:0]   servo_ready_in,    // servo ready pin
	input  wire logic [AXES-1:0]   axis_booted,       // start-up done, same clock
	input  wire logic [AXES-1:0]   auto_decel,        // auto decel, same clock
	input  wire logic [AXES-1:0]   jog_start_fwd_rev, // jog start pins
	input  wire logic [4*AXES-1:0] axis_mode,         // mode per axis, same clock
	output logic      [AXES-1:0]   err_flag,          // per-axis error flag
	output logic      [AXES-1:0]   pos_load,          // pulse: position written
	output logic      [AXES-1:0]   vel_load,          // pulse: velocity written
	output logic      [31:0]       load_value         // value with load pulse
);
	import chk_pkg::*;
	// refuse axis counts that the 3-bit axis field cannot address
	if (AXES < 1 || AXES > 8)
	begin : g_bad_axes
		$error("AXES must be 1..8");
	end

	// ***********************
	// state
	// ***********************
	typedef struct packed {
		logic [31:0]            prdata;
		logic                   pready;
		logic                   pslverr;
		logic [31:0]            vlimit;
		logic [AXES-1:0][31:0]  pos;     // current position store
		logic [AXES-1:0][31:0]  vel;     // commanded velocity store
		logic [AXES-1:0][15:0]  err;     // latched code per axis
		logic [AXES-1:0]        flag;
		logic [AXES-1:0]        pos_load;
		logic [AXES-1:0]        vel_load;
		logic [31:0]            load_value;
		logic                   busy;    // request in flight
		logic [2:0]             sel;     // axis for reads
	} state_t;
	state_t s_r, s_nxt;

	chk_if            ci ();
	logic [AXES-1:0]  ready_s; // synced servo ready
	logic [AXES-1:0]  jog_s;   // synced jog start
	logic             wr_acc;  // apb write access phase

	// pin levels pass two flops first
	axis_sync #(.W(2*AXES)) u_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     ({jog_start_fwd_rev, servo_ready_in}),
		.q     ({jog_s, ready_s})
	);

	chk_core #(.AXES(AXES)) u_core (
		.clk               (pclk),
		.rst_n             (presetn),
		.bus               (ci.core),
		.start_accept_flag (start_accept_flag),
		.servo_ready_sync  (ready_s),
		.booted            (axis_booted),
		.auto_decel        (auto_decel),
		.jog_fwd_rev_sync  (jog_s),
		.mode_flat         (axis_mode),
		.vlimit            (s_r.vlimit)
	);

	// true when a code lies in the allowed band
	function automatic logic code_ok(input logic [15:0] c);
		return c >= `ERR_MIN && c <= `ERR_MAX;
	endfunction : code_ok

	// pready held low while a request is in flight, stretching the access
	assign wr_acc = psel && penable && pwrite && !s_r.busy;

	// request issue: first access cycle of a REQ write launches it once
	always_comb
	begin
		ci.req_valid = wr_acc && s_r.pready == 1'b0 && paddr == `OFF_REQ && !s_r.busy;
		ci.req_kind  = pwdata[`REQ_POS_BIT] ? REQ_POS : (pwdata[`REQ_VEL_BIT] ? REQ_VEL : REQ_NONE);
		ci.axis      = pwdata[`REQ_AXIS_LSB +: 3];
		ci.value     = s_r.load_value;
		if (ci.req_kind == REQ_NONE || 32'(ci.axis) >= AXES)
			ci.req_valid = 1'b0;
	end

	// ***********************
	// register file and verdict handling
	// ***********************
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.pready = 1'b0;
		s_nxt.pslverr = 1'b0;
		s_nxt.pos_load = '0;
		s_nxt.vel_load = '0;
		if (ci.req_valid)
			s_nxt.busy = 1'b1;
		// verdict back: store value or refuse, latch code
		if (ci.done)
		begin
			s_nxt.busy = 1'b0;
			s_nxt.pready = 1'b1; // finishes the REQ write
			if (ci.accept && pwdata[`REQ_POS_BIT])
			begin
				s_nxt.pos[ci.axis] = ci.applied;
				s_nxt.pos_load[ci.axis] = 1'b1;
			end
			else if (ci.accept)
			begin
				s_nxt.vel[ci.axis] = ci.applied;
				s_nxt.vel_load[ci.axis] = 1'b1;
			end
			// refused: stores stay as they were
			if (ci.code != `ERR_NONE && code_ok(ci.code))
			begin
				s_nxt.err[ci.axis] = ci.code;
				s_nxt.flag[ci.axis] = 1'b1;
			end
			s_nxt.load_value = ci.applied;
		end
		else if (psel && penable && !s_r.pready && !s_r.busy && !ci.req_valid)
		begin
			s_nxt.pready = 1'b1;
			if (pwrite)
			begin
				if (paddr == `OFF_CTRL)
					s_nxt.sel = pwdata[2:0];
				else if (paddr == `OFF_VLIMIT)
					s_nxt.vlimit = pwdata;
				else if (paddr == `OFF_POS)
					s_nxt.load_value = pwdata; // staging value
				else if (paddr == `OFF_ERR)
				begin
					// write one clears; a new error in same cycle cannot occur here
					s_nxt.flag = s_r.flag & ~pwdata[AXES-1:0];
				end
				else if (paddr == `OFF_REQ)
					s_nxt.pready = 1'b1; // empty request
				else
					s_nxt.pslverr = 1'b1;
			end
			else
			begin
				if (paddr == `OFF_CTRL)
					s_nxt.prdata = 32'(s_r.sel);
				else if (paddr == `OFF_VLIMIT)
					s_nxt.prdata = s_r.vlimit;
				else if (paddr == `OFF_POS)
					s_nxt.prdata = s_r.pos[s_r.sel];
				else if (paddr == `OFF_VEL)
					s_nxt.prdata = s_r.vel[s_r.sel];
				else if (paddr == `OFF_ERR)
					s_nxt.prdata = {16'h0000, s_r.err[s_r.sel]};
				else if (paddr == `OFF_STAT)
					s_nxt.prdata = 32'(s_r.flag);
				else
				begin
					s_nxt.prdata = 32'h00000000;
					s_nxt.pslverr = 1'b1;
				end
			end
		end
	end

	// single register stage for all state
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			s_r <= '0;
			s_r.vlimit <= `RST_VLIMIT;
		end
		else
			s_r <= s_nxt;

	assign prdata     = s_r.prdata;
	assign pready     = s_r.pready;
	assign pslverr    = s_r.pslverr;
	assign err_flag   = s_r.flag;
	assign pos_load   = s_r.pos_load;
	assign vel_load   = s_r.vel_load;
	assign load_value = s_r.load_value;
endmodule : axis_change_request_checker

// ==== chk_asserts.sv ====
`timescale 1ns/1ps
`include "chk_defines.svh"
// ****
// checker on the top ports
// ****
module chk_asserts
	import chk_pkg::*;
#(
	parameter int AXES = 8 // axis count
)(
	input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata, prdata, load_value,
	input wire logic [AXES-1:0] start_accept_flag, servo_ready_in, axis_booted, auto_decel,
	input wire logic [AXES-1:0] jog_start_fwd_rev, err_flag, pos_load, vel_load,
	input wire logic [4*AXES-1:0] axis_mode
);
	logic [AXES-1:0] zr, ci; // axes in zero return / circular mode
	// mode decode per axis
	always_comb
	begin
		for (int i = 0; i < AXES; i++)
		begin
			zr[i] = axis_mode[4*i+:4] == MODE_ZRET;
			ci[i] = axis_mode[4*i+:4] == MODE_CIRC;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// setup cycle of any access
	sequence s_setup;
		psel && !penable;
	endsequence
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_setup_answer: assert property (s_setup |-> ##[1:4] pready)
		else $error("access not answered");
	a_pos_busy: assert property (!(|(pos_load & start_accept_flag & $past(start_accept_flag))))
		else $error("position loaded on moving axis");
	a_pos_boot: assert property (!(|(pos_load & ~axis_booted & ~$past(axis_booted))))
		else $error("position loaded before start-up");
	a_vel_zret: assert property (!(|(vel_load & zr & $past(zr))))
		else $error("velocity loaded in zero return");
	a_vel_circ: assert property (!(|(vel_load & ci & $past(ci))))
		else $error("velocity loaded in circular move");
	a_vel_decel: assert property (!(|(vel_load & auto_decel & $past(auto_decel))))
		else $error("velocity loaded after auto decel");
	a_flag_hold: assert property (|($past(err_flag) & ~err_flag) |-> $past(psel && pwrite && paddr == `OFF_ERR))
		else $error("error flag dropped without clear");
endmodule : chk_asserts
bind axis_change_request_checker chk_asserts #(.AXES(AXES)) u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .load_value(load_value), .start_accept_flag(start_accept_flag),
	.servo_ready_in(servo_ready_in), .axis_booted(axis_booted), .auto_decel(auto_decel),
	.jog_start_fwd_rev(jog_start_fwd_rev), .err_flag(err_flag), .pos_load(pos_load),
	.vel_load(vel_load), .axis_mode(axis_mode));

// ==== host_cpu.sv ====
`timescale 1ns/1ps
// ****
// host sequence cpu as apb master
// ****
module host_cpu (
	input  wire logic        pclk,    // system clock
	input  wire logic [31:0] prdata,  // read data
	input  wire logic        pready,  // slave answer
	input  wire logic        pslverr, // slave error
	output logic             psel,    // select
	output logic             penable, // enable
	output logic             pwrite,  // direction
	output logic [11:0]      paddr,   // address
	output logic [31:0]      pwdata   // write data
);
	// bus idle at time zero
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
	end
	// interlock for position change; callers may skip it to provoke refusals
	function automatic logic interlock_ok(input logic busy, input logic ready);
		return !busy && ready;
	endfunction : interlock_ok
	// one transfer, held until pready is seen
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
endmodule : host_cpu

// ==== tb.sv ====
`timescale 1ns/1ps
`include "chk_defines.svh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin n_fail++; \
	$display("wrong value %s expected %h seen %h", nm, e, s); end end
module tb;
	import chk_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, load_value, rd, md;
	logic [7:0]  sa, sr, bt, ad, jg, err_flag, pos_load, vel_load;
	int          n_fail, n_compared, cyc, npos, nvel;
	// ****
	// clock, load counters, timeout
	// ****
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		cyc++;
		npos += $countones(pos_load);
		nvel += $countones(vel_load);
		if (cyc == 20000)
		begin
			n_fail++;
			end_of_test();
		end
	end
	host_cpu u_host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	axis_change_request_checker dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .start_accept_flag(sa), .servo_ready_in(sr), .axis_booted(bt),
		.auto_decel(ad), .jog_start_fwd_rev(jg), .axis_mode(md), .err_flag(err_flag),
		.pos_load(pos_load), .vel_load(vel_load), .load_value(load_value));
	// ****
	// bus helpers
	// ****
	task wr(input logic [11:0] a, input logic [31:0] d);
		u_host.xfer(1'b1, a, d, rd, er);
	endtask : wr
	task rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
		u_host.xfer(1'b0, a, 32'h0, rd, er);
		`CHK(nm, e, rd)
	endtask : rd_chk
	// stage value, request, then select the axis for read back
	task req(input logic [1:0] kb, input logic [2:0] ax, input logic [31:0] v);
		wr(`OFF_POS, v);
		wr(`OFF_REQ, {25'h0, ax, 2'b00, kb});
		wr(`OFF_CTRL, {29'h0, ax});
	endtask : req
	// ****
	// scenarios
	// ****
	task t_reg();
		rd_chk("vlimit", `OFF_VLIMIT, `RST_VLIMIT);
		u_host.xfer(1'b0, 12'hffc, 32'h0, rd, er);
		`CHK("slverr", 1'b1, er)
		$display("t_reg done");
	endtask : t_reg
	task t_pos();
		sa[1] <= 1'b1; // moving
		bt[2] <= 1'b0; // not started up
		sr[3] <= 1'b0; // servo off
		for (int a = 1; a < 4; a++)
		begin
			req(2'b01, a[2:0], 32'h55);
			rd_chk("pos err", `OFF_ERR, `ERR_POS);
			rd_chk("pos kept", `OFF_POS, 32'h0);
		end
		`CHK("no pos load", 0, npos)
		rd_chk("flags", `OFF_STAT, 32'h0e);
		`CHK("err_flag", 8'h0e, err_flag)
		wr(`OFF_ERR, 32'hff);
		rd_chk("cleared", `OFF_STAT, 32'h0);
		`CHK("interlock", 1'b1, u_host.interlock_ok(sa[0], sr[0]))
		req(2'b01, 3'd0, 32'h1234);
		rd_chk("pos set", `OFF_POS, 32'h1234);
		`CHK("pos loads", 1, npos)
		$display("t_pos done");
	endtask : t_pos
	task automatic t_vel();
		mode_t m[4] = '{MODE_ZRET, MODE_CIRC, MODE_VELO, MODE_JOG};
		logic [15:0] c[4] = '{`ERR_ZRET, `ERR_CIRC, `ERR_AUTODEC, `ERR_JOGDEC};
		md[19:16] <= MODE_VELO;
		req(2'b10, 3'd4, 32'h100);
		for (int i = 0; i < 4; i++)
		begin
			md[19:16] <= m[i];
			ad[4] <= (i == 2);
			req(2'b10, 3'd4, 32'h200);
			rd_chk("vel err", `OFF_ERR, c[i]);
			rd_chk("vel kept", `OFF_VEL, 32'h100);
		end
		md[19:16] <= MODE_VELO;
		ad[4] <= 1'b0;
		req(2'b10, 3'd4, 32'h10000);
		rd_chk("range err", `OFF_ERR, `ERR_RANGE);
		rd_chk("clamped", `OFF_VEL, `RST_VLIMIT);
		`CHK("applied", `RST_VLIMIT, load_value)
		// negative request against a lowered limit
		wr(`OFF_VLIMIT, 32'h800);
		req(2'b10, 3'd4, 32'hffffff00);
		rd_chk("neg err", `OFF_ERR, `ERR_RANGE);
		rd_chk("neg clamp", `OFF_VEL, 32'h800);
		// jog with start held is not decelerating, so accepted
		md[19:16] <= MODE_JOG;
		jg[4] <= 1'b1;
		req(2'b10, 3'd4, 32'h300);
		rd_chk("jog held", `OFF_VEL, 32'h300);
		`CHK("vel loads", 4, nvel)
		$display("t_vel done");
	endtask : t_vel
	task end_of_test();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test
	// main sequence
	initial
	begin
		presetn = 1'b0;
		{sa, ad, jg, md} = '0;
		sr = 8'hff;
		bt = 8'hff;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reg();
		t_pos();
		t_vel();
		end_of_test();
	end
endmodule : tb
